// *** src/pcq_pkg.sv ***
package pcq_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h50;
	localparam logic [7:0] OFS_STS = 8'h54;
	localparam logic [7:0] OFS_TOUT = 8'h58;
	localparam logic [7:0] OFS_DATA = 8'h60;

	// ----------------------------------------------------------------
	// Control layout, bits 13:0 of the control word
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] source_channel_pick;
		logic rsv11;
		logic source_pick_enable;
		logic timeout_en;
		logic dma_mode_en;
		logic rsv7;
		logic [2:0] watermark;
		logic wm_ie;
		logic ovf_ie;
		logic full_ie;
		logic mode_sel;
	} pcq_ctrl_t;

	localparam int CTRL_W = 14;
	localparam logic [13:0] CTRL_WMASK = 14'h377f;
	localparam logic [13:0] CTRL_RST = 14'h0000;

	// ----------------------------------------------------------------
	// Status layout
	// ----------------------------------------------------------------
	localparam int STS_FULL = 0;
	localparam int STS_OVF = 1;
	localparam int STS_WM = 2;
	localparam int STS_TOUT = 3;
	localparam int STS_EMPTY = 4;
	localparam logic [3:0] STS_RST = 4'h0;

	// ----------------------------------------------------------------
	// Queue geometry and fields
	// ----------------------------------------------------------------
	localparam int DEPTH = 8;
	localparam int PTR_W = 3;
	localparam logic [3:0] FILL_FULL = 4'h8;
	localparam logic [1:0] CH_THREE = 2'h3;
	localparam int TOUT_W = 20;
	localparam int LEVEL_BIT = 31;

	typedef struct packed {
		logic level;
		logic [30:0] cycles;
	} pcq_cap_t;

endpackage

// *** src/pcq_fifo.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - Pick enable set: route picked channel
// - Pick enable clear: always feed channel three
// - Hold 20-bit timeout threshold in clocks
// - Three-bit programmable watermark level
// - Set watermark flag when fill exceeds level
// - Overflow enable raises interrupt on overflow
// - Full enable raises interrupt when full
// - Queue works only while mode set
// - Empty flag reads one when empty
// - Overflow flag when entry arrives while full with no pop
// - Full flag records queue reached full
// - Entry top bit carries pulse level
// - Entry low 31 bits carry pulse cycles
module pcq_fifo (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic [3:0] i_cap_valid,
	input wire pcq_pkg::pcq_cap_t [3:0] i_cap,
	output logic o_dma_req,
	output logic o_irq
);

	// ----------------------------------------------------------------
	// Storage and registers
	// ----------------------------------------------------------------
	pcq_pkg::pcq_ctrl_t ctrl_ff;
	logic [19:0] tout_thr_ff;
	logic [3:0] sts_ff;
	logic [3:0] nxt_sts;
	logic [31:0] mem_ff [pcq_pkg::DEPTH];
	logic [2:0] wr_ptr_ff;
	logic [2:0] rd_ptr_ff;
	logic [3:0] fill_ff;
	logic [3:0] nxt_fill;
	logic [19:0] idle_cnt_ff;
	logic [31:0] rdata_ff;
	logic dma_req_ff;
	logic irq_ff;

	logic [1:0] src_idx;
	logic push;
	logic pop;
	logic accept;
	logic overflow;
	logic empty;
	logic wm_hit;
	logic tout_hit;
	logic [3:0] sts_set;
	logic [3:0] sts_clr;
	logic [3:0] irq_mask;

	assign empty = (fill_ff == 4'h0);

	// ----------------------------------------------------------------
	// Source selection and queue handshake
	// ----------------------------------------------------------------
	always_comb begin
		if (ctrl_ff.source_pick_enable) begin
			src_idx = ctrl_ff.source_channel_pick;
		end else begin
			src_idx = pcq_pkg::CH_THREE;
		end
	end

	assign push = ctrl_ff.mode_sel && i_cap_valid[src_idx];
	assign pop = i_rd && (i_addr == pcq_pkg::OFS_DATA) && !empty;
	// A pop in the same cycle frees a slot, so a full queue still takes the entry
	assign accept = push && ((fill_ff != pcq_pkg::FILL_FULL) || pop);
	assign overflow = push && !accept;

	always_comb begin
		nxt_fill = fill_ff;
		if (accept && !pop) begin
			nxt_fill = fill_ff + 4'h1;
		end else if (pop && !accept) begin
			nxt_fill = fill_ff - 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// Queue memory and pointers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_ce && accept) begin
			mem_ff[wr_ptr_ff] <= i_cap[src_idx];
		end
	end

	// Leaving queue mode drops whatever is queued
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wr_ptr_ff <= 3'h0;
			rd_ptr_ff <= 3'h0;
			fill_ff <= 4'h0;
		end else if (i_ce) begin
			if (!ctrl_ff.mode_sel) begin
				wr_ptr_ff <= 3'h0;
				rd_ptr_ff <= 3'h0;
				fill_ff <= 4'h0;
			end else begin
				if (accept) begin
					wr_ptr_ff <= wr_ptr_ff + 3'h1;
				end
				if (pop) begin
					rd_ptr_ff <= rd_ptr_ff + 3'h1;
				end
				fill_ff <= nxt_fill;
			end
		end
	end

	// ----------------------------------------------------------------
	// Inactivity timer
	// ----------------------------------------------------------------
	assign tout_hit = ctrl_ff.timeout_en && !empty && (tout_thr_ff != 20'h00000)
		&& (idle_cnt_ff >= tout_thr_ff);

	// Counter saturates at the threshold so a slow reader sees one steady flag
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			idle_cnt_ff <= 20'h00000;
		end else if (i_ce) begin
			if (!ctrl_ff.timeout_en || empty || accept) begin
				idle_cnt_ff <= 20'h00000;
			end else if (idle_cnt_ff < tout_thr_ff) begin
				idle_cnt_ff <= idle_cnt_ff + 20'h00001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Status flags
	// ----------------------------------------------------------------
	assign wm_hit = (fill_ff > {1'b0, ctrl_ff.watermark});

	always_comb begin
		sts_set = 4'h0;
		sts_set[pcq_pkg::STS_FULL] = (fill_ff == pcq_pkg::FILL_FULL);
		sts_set[pcq_pkg::STS_OVF] = overflow;
		sts_set[pcq_pkg::STS_WM] = wm_hit;
		sts_set[pcq_pkg::STS_TOUT] = tout_hit;
		sts_clr = 4'h0;
		if (i_wr && (i_addr == pcq_pkg::OFS_STS)) begin
			sts_clr = i_wdata[3:0];
		end
		// Set wins over a clear that lands in the same cycle
		nxt_sts = (sts_ff & ~sts_clr) | sts_set;
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sts_ff <= pcq_pkg::STS_RST;
		end else if (i_ce) begin
			sts_ff <= nxt_sts;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt and DMA request
	// ----------------------------------------------------------------
	always_comb begin
		irq_mask = 4'h0;
		irq_mask[pcq_pkg::STS_FULL] = ctrl_ff.full_ie;
		irq_mask[pcq_pkg::STS_OVF] = ctrl_ff.ovf_ie;
		irq_mask[pcq_pkg::STS_WM] = ctrl_ff.wm_ie;
		irq_mask[pcq_pkg::STS_TOUT] = ctrl_ff.timeout_en;
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			irq_ff <= 1'b0;
		end else if (i_ce) begin
			irq_ff <= |(sts_ff & irq_mask);
		end
	end

	// Request follows the fill of the next cycle so a drained queue drops it at once
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			dma_req_ff <= 1'b0;
		end else if (i_ce) begin
			dma_req_ff <= ctrl_ff.dma_mode_en && ctrl_ff.mode_sel
				&& (nxt_fill != 4'h0);
		end
	end

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ctrl_ff <= pcq_pkg::pcq_ctrl_t'(pcq_pkg::CTRL_RST);
			tout_thr_ff <= 20'h00000;
		end else if (i_ce && i_wr) begin
			if (i_addr == pcq_pkg::OFS_CTRL) begin
				ctrl_ff <= pcq_pkg::pcq_ctrl_t'(i_wdata[13:0] & pcq_pkg::CTRL_WMASK);
			end
			if (i_addr == pcq_pkg::OFS_TOUT) begin
				tout_thr_ff <= i_wdata[19:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Register reads
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rdata_ff <= 32'h00000000;
		end else if (i_ce) begin
			rdata_ff <= 32'h00000000;
			if (i_rd) begin
				case (i_addr)
					pcq_pkg::OFS_CTRL: begin
						rdata_ff <= {18'h00000, ctrl_ff};
					end
					pcq_pkg::OFS_STS: begin
						rdata_ff <= {27'h0000000, empty, sts_ff};
					end
					pcq_pkg::OFS_TOUT: begin
						rdata_ff <= {12'h000, tout_thr_ff};
					end
					pcq_pkg::OFS_DATA: begin
						if (!empty) begin
							rdata_ff <= mem_ff[rd_ptr_ff];
						end
					end
					default: begin
						rdata_ff <= 32'h00000000;
					end
				endcase
			end
		end
	end

	assign o_rdata = rdata_ff;
	assign o_dma_req = dma_req_ff;
	assign o_irq = irq_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);

	sequence s_status_read;
		i_ce && i_rd && (i_addr == pcq_pkg::OFS_STS);
	endsequence

	sequence s_data_pop;
		i_ce && pop;
	endsequence

	a_pick_route: assert property (
		(i_ce && ctrl_ff.source_pick_enable && ctrl_ff.mode_sel
			&& i_cap_valid[ctrl_ff.source_channel_pick]) |-> push)
		else $error("picked channel entry not pushed");

	a_default_three: assert property (
		(!ctrl_ff.source_pick_enable && ctrl_ff.mode_sel) |-> (push == i_cap_valid[3]))
		else $error("channel three not used by default");

	a_mode_gate: assert property (
		(i_ce && !ctrl_ff.mode_sel) |=> (fill_ff == 4'h0))
		else $error("queue holds data while mode is off");

	a_empty_read: assert property (
		s_status_read |=> (o_rdata[pcq_pkg::STS_EMPTY] == $past(empty)))
		else $error("empty flag wrong on status read");

	a_overflow_flag: assert property (
		(i_ce && push && (fill_ff == pcq_pkg::FILL_FULL) && !pop) |=> sts_ff[pcq_pkg::STS_OVF])
		else $error("overflow not flagged");

	a_full_flag: assert property (
		(i_ce && (fill_ff == pcq_pkg::FILL_FULL)) |=> sts_ff[pcq_pkg::STS_FULL])
		else $error("full not flagged");

	a_watermark_flag: assert property (
		(i_ce && (fill_ff > {1'b0, ctrl_ff.watermark})) |=> sts_ff[pcq_pkg::STS_WM])
		else $error("watermark not flagged");

	a_full_irq: assert property (
		(i_ce && sts_ff[pcq_pkg::STS_FULL] && ctrl_ff.full_ie) |=> o_irq)
		else $error("full interrupt missing");

	a_overflow_irq: assert property (
		(i_ce && sts_ff[pcq_pkg::STS_OVF] && ctrl_ff.ovf_ie) |=> o_irq)
		else $error("overflow interrupt missing");

	a_pop_data: assert property (
		s_data_pop |=> (o_rdata == $past(mem_ff[rd_ptr_ff])))
		else $error("popped entry does not match head");

	a_timeout_flag: assert property (
		(i_ce && tout_hit) |=> sts_ff[pcq_pkg::STS_TOUT])
		else $error("timeout not flagged");

	a_dma_request: assert property (
		(i_ce && ctrl_ff.dma_mode_en && ctrl_ff.mode_sel && (fill_ff > 4'h1)) |=> o_dma_req)
		else $error("dma request missing with data queued");

	a_w1c_clear: assert property (
		(i_ce && i_wr && (i_addr == pcq_pkg::OFS_STS) && i_wdata[pcq_pkg::STS_OVF]
			&& !overflow) |=> !sts_ff[pcq_pkg::STS_OVF])
		else $error("overflow flag not cleared by write one");

	a_entry_level: assert property (
		(i_ce && accept) |=> (mem_ff[$past(wr_ptr_ff)][pcq_pkg::LEVEL_BIT]
			== $past(i_cap[src_idx].level)))
		else $error("stored level bit differs from capture");

	a_entry_cycles: assert property (
		(i_ce && accept) |=> (mem_ff[$past(wr_ptr_ff)][30:0]
			== $past(i_cap[src_idx].cycles)))
		else $error("stored cycle count differs from capture");

	a_empty_data: assert property (
		(i_ce && i_rd && (i_addr == pcq_pkg::OFS_DATA) && empty)
			|=> (o_rdata == 32'h00000000))
		else $error("read of empty queue returned data");

	a_fill_up: assert property (
		(i_ce && ctrl_ff.mode_sel && accept && !pop)
			|=> (fill_ff == $past(fill_ff) + 4'h1))
		else $error("fill did not count an accepted entry");

	a_fill_down: assert property (
		(i_ce && ctrl_ff.mode_sel && pop && !accept)
			|=> (fill_ff == $past(fill_ff) - 4'h1))
		else $error("fill did not count a popped entry");

	a_ovf_sticky: assert property (
		(i_ce && sts_ff[pcq_pkg::STS_OVF]
			&& !(i_wr && (i_addr == pcq_pkg::OFS_STS) && i_wdata[pcq_pkg::STS_OVF]))
			|=> sts_ff[pcq_pkg::STS_OVF])
		else $error("overflow flag lost without a clear");

	a_idle_count: assert property (
		(i_ce && ctrl_ff.timeout_en && !empty && !accept && (idle_cnt_ff < tout_thr_ff))
			|=> (idle_cnt_ff == $past(idle_cnt_ff) + 20'h00001))
		else $error("idle counter did not advance");

	a_thr_hold: assert property (
		(i_ce && !(i_wr && (i_addr == pcq_pkg::OFS_TOUT)))
			|=> (tout_thr_ff == $past(tout_thr_ff)))
		else $error("timeout threshold changed without a write");

	a_timeout_irq: assert property (
		(i_ce && sts_ff[pcq_pkg::STS_TOUT] && ctrl_ff.timeout_en) |=> o_irq)
		else $error("timeout interrupt missing");

	a_irq_quiet: assert property (
		(i_ce && ((sts_ff & irq_mask) == 4'h0)) |=> !o_irq)
		else $error("interrupt raised with no unmasked flag");

	a_dma_drop: assert property (
		(i_ce && (nxt_fill == 4'h0)) |=> !o_dma_req)
		else $error("dma request stays with queue drained");

	a_dma_off: assert property (
		(i_ce && !ctrl_ff.dma_mode_en) |=> !o_dma_req)
		else $error("dma request while dma mode is off");

endmodule

// *** verification/pcq_cap_model.sv ***
`timescale 1ns/100ps
module pcq_cap_model (
	input wire logic i_clk,
	output logic [3:0] o_valid,
	output pcq_pkg::pcq_cap_t [3:0] o_cap
);
	// ----------------------------------------------------------------
	// Four-channel capture source
	// ----------------------------------------------------------------
	initial begin
		o_valid = 4'h0;
		o_cap = '0;
	end

	// Channel i carries v plus i, so a wrong channel pick shows in the data.
	// Data is inverted once the strobe drops, so a stale sample never matches.
	task automatic send(input logic [3:0] m, input logic [31:0] v);
		@(posedge i_clk);
		o_valid <= m;
		for (int i = 0; i < 4; i++) begin
			o_cap[i] <= v + 32'(i);
		end
		@(posedge i_clk);
		o_valid <= 4'h0;
		for (int i = 0; i < 4; i++) begin
			o_cap[i] <= ~(v + 32'(i));
		end
	endtask
endmodule

// *** verification/pcq_fifo_tb.sv ***
`timescale 1ns/100ps
module pcq_fifo_tb;
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_ce = 1'b1;
	logic [31:0] o_rdata;
	logic [3:0] cap_valid;
	pcq_pkg::pcq_cap_t [3:0] cap_data;
	logic o_dma_req;
	logic o_irq;
	int error_cnt = 0;
	int cmp_count = 0;

	always #2.5 i_clk = ~i_clk;

	pcq_cap_model cap (.i_clk(i_clk), .o_valid(cap_valid), .o_cap(cap_data));

	pcq_fifo dut (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_ce(i_ce),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_wr(i_wr),
		.i_rd(i_rd),
		.o_rdata(o_rdata),
		.i_cap_valid(cap_valid),
		.i_cap(cap_data),
		.o_dma_req(o_dma_req),
		.o_irq(o_irq)
	);

	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, exp);
	endtask

	task automatic sts(input logic [31:0] exp);
		rd(pcq_pkg::OFS_STS, exp);
	endtask

	task automatic pop(input logic [31:0] exp);
		rd(pcq_pkg::OFS_DATA, exp);
	endtask

	task automatic ctl(input logic [31:0] d);
		wr(pcq_pkg::OFS_CTRL, d);
	endtask

	// One cycle of slack: both outputs are registered behind their cause
	task automatic flg(input logic [1:0] exp);
		@(posedge i_clk);
		#1;
		chk({30'h0, o_irq, o_dma_req}, {30'h0, exp});
	endtask

	task automatic tally_and_finish;
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge i_clk);
		i_rstn <= 1'b1;
		sts(32'h10);
		rd(pcq_pkg::OFS_CTRL, 32'h0);
		rd(8'h5c, 32'h0);
		flg(2'b00);
		cap.send(4'hf, 32'h0000_0020);
		sts(32'h10);
		ctl(32'h1);
		cap.send(4'h1, 32'h0000_0030);
		sts(32'h10);
		cap.send(4'hf, 32'h8000_0010);
		pop(32'h8000_0013);
		pop(32'h0);
		for (int c = 0; c < 4; c++) begin
			ctl(32'h401 | (32'(c) << 12));
			cap.send(4'hf, 32'h1000_0040);
			pop(32'h1000_0040 + 32'(c));
		end
		wr(pcq_pkg::OFS_STS, 32'hf);
		sts(32'h10);
		ctl(32'h35);
		for (int i = 0; i < 8; i++) begin
			cap.send(4'h8, 32'(i));
			if (i == 2) sts(32'h0);
			if (i == 3) sts(32'h4);
		end
		sts(32'h5);
		flg(2'b00);
		ctl(32'h37);
		flg(2'b10);
		ctl(32'h35);
		cap.send(4'h8, 32'h64);
		sts(32'h7);
		flg(2'b10);
		wr(pcq_pkg::OFS_STS, 32'h2);
		wr(pcq_pkg::OFS_STS, 32'h0);
		sts(32'h5);
		flg(2'b00);
		ctl(32'h135);
		flg(2'b01);
		for (int i = 0; i < 8; i++) begin
			pop(32'(i + 3));
		end
		flg(2'b00);
		sts(32'h15);
		wr(pcq_pkg::OFS_STS, 32'hf);
		wr(pcq_pkg::OFS_TOUT, 32'hffff_ffff);
		rd(pcq_pkg::OFS_TOUT, 32'h000f_ffff);
		wr(pcq_pkg::OFS_TOUT, 32'h6);
		ctl(32'h271);
		cap.send(4'h8, 32'h8000_0100);
		sts(32'h0);
		repeat (10) @(posedge i_clk);
		sts(32'h8);
		flg(2'b10);
		pop(32'h8000_0103);
		wr(pcq_pkg::OFS_STS, 32'hf);
		sts(32'h10);
		// Clock enable low freezes the queue, so this capture is never taken
		i_ce <= 1'b0;
		cap.send(4'h8, 32'h0000_0055);
		i_ce <= 1'b1;
		sts(32'h10);
		tally_and_finish();
	end

	// Cuts a hang short; the whole sequence needs far fewer cycles
	initial begin
		repeat (4000) @(posedge i_clk);
		error_cnt++;
		tally_and_finish();
	end
endmodule
